// ### dps_consts.vh
/*
  constants for the drive state and parameter store block:
  object indices, signatures, status codes, field positions and
  nonvolatile layout.
  assumes it is included by bare name from each design file.
*/
`ifndef DPS_CONSTS_VH
`define DPS_CONSTS_VH
// object dictionary indices
`define DPS_OBJ_CTRL      16'h6040
`define DPS_OBJ_STAT      16'h6041
`define DPS_OBJ_QSOPT     16'h605a
`define DPS_OBJ_MODE      16'h6060
`define DPS_OBJ_MODE_DISP 16'h6061
`define DPS_OBJ_ACT_VEL   16'h606c
`define DPS_OBJ_SIGN      16'h607e
`define DPS_OBJ_ACCEL     16'h6083
`define DPS_OBJ_TGT_VEL   16'h60ff
`define DPS_OBJ_HBEAT     16'h1017
`define DPS_OBJ_BRAKE     16'h3002
`define DPS_OBJ_STORE     16'h1010
`define DPS_OBJ_RESTORE   16'h1011
// signatures "save" and "load", low byte first
`define DPS_SIG_SAVE      32'h65766173
`define DPS_SIG_LOAD      32'h64616f6c
// store / restore subindices
`define DPS_SUB_ALL       8'h01
`define DPS_SUB_COMM      8'h02
`define DPS_SUB_APP       8'h03
`define DPS_SUB_MFR       8'h04
// motion sign select fields
`define DPS_SIGN_POS      7
`define DPS_SIGN_VEL      6
`define DPS_SIGN_RST      8'h00
// status word codes per state
`define DPS_SW_SOD        16'h0040
`define DPS_SW_READY      16'h0021
`define DPS_SW_SWON       16'h0023
`define DPS_SW_RUN        16'h0027
`define DPS_SW_QHALT      16'h0007
`define DPS_SW_FAULT      16'h0008
// control word commands and bits
`define DPS_CW_SHUTDOWN   8'h06
`define DPS_CW_SWITCH_ON  8'h07
`define DPS_CW_ENABLE     8'h0f
`define DPS_CW_EV         1
`define DPS_CW_QS         2
`define DPS_CW_FRESET     7
`define DPS_CW_HALT       8
// operating mode and quick stop option
`define DPS_MODE_RST      8'h00
`define DPS_QSOPT_RST     16'h0000
`define DPS_QSOPT_TO_SOD  16'h0000
// nonvolatile word layout (user area 0..3, factory area 4..7)
`define DPS_NV_HBEAT      2'h0
`define DPS_NV_SIGN       2'h1
`define DPS_NV_ACCEL      2'h2
`define DPS_NV_BRAKE      2'h3
// factory values
`define DPS_BRAKE_US      100
`define DPS_CLK_MHZ       20
`define DPS_BRAKE_CYC     (`DPS_BRAKE_US * `DPS_CLK_MHZ)
`define DPS_GOLD_HBEAT    32'h00000000
`define DPS_GOLD_SIGN     32'h00000000
`define DPS_GOLD_ACCEL    32'h00000064
`endif

// ### dps_drive_ctrl.v
/*
  drive state machine and parameter store behind an object
  dictionary port, with velocity ramp, sign select and brake.
  assumes od_* and nmt_* come from fieldbus logic on sys_clk;
  safety, stop and fault arrive asynchronously on pins.
*/
// Behaviour
// - switched on: amp standby, drive off
// - running: drive on, power, brake releases
// - quick halt ramps down, option 0 disables
// - fault reaction hidden, passes to fault
// - fault state: drive off, parameters writable
// - switched on reports status 0x23
// - running reports status 0x27
// - target velocity in, actual velocity out
// - safe torque off stops motor at once
// - stop command aborts current command
// - detected fault aborts current command
// - sign object: bits 7,6, rest zero
// - sign bit set negates demand values
// - save signature stores selected group
// - subindex 2 comm, 3 app, 4 maker
// - nmt resets reload stored parameters
// - after store refuse edits until comm reset
// - factory group in protected area
// - load signature restores factory values
// - unstored edits lost at power off
// - status bit5 low quick halt, bit3 fault
`timescale 1ns/1ps
`include "dps_consts.vh"
module dps_drive_ctrl
(
  input  wire        sys_clk,
  input  wire        resetn,
  input  wire        od_wr,
  input  wire        od_rd,
  input  wire [15:0] od_index,
  input  wire [7:0]  od_sub,
  input  wire [31:0] od_wdata,
  output reg  [31:0] od_rdata,
  output reg         od_ack,
  output reg         od_err,
  input  wire        nmt_reset_node,
  input  wire        nmt_reset_comm,
  input  wire        safe_torque_off_command,
  input  wire        stop_request,
  input  wire        fault_detect,
  input  wire [31:0] pos_request,
  output reg         amp_standby,
  output reg         drive_enable,
  output reg         motor_power,
  output reg         brake_release,
  output reg  [31:0] velocity_demand,
  output reg  [31:0] pos_demand,
  output reg  [15:0] status_word,
  output reg         store_locked
);
  // drive states
  localparam [2:0] ST_SOD    = 3'h0;  // switch on disabled
  localparam [2:0] ST_READY  = 3'h1;
  localparam [2:0] ST_SWON   = 3'h2;  // switched_on_state
  localparam [2:0] ST_RUN    = 3'h3;  // running_state
  localparam [2:0] ST_QHALT  = 3'h4;  // quick_halt_state
  localparam [2:0] ST_FREACT = 3'h5;  // fault_reaction_state
  localparam [2:0] ST_FAULT  = 3'h6;  // fault_state
  // copy engine operations
  localparam [1:0] OP_STORE   = 2'h0;
  localparam [1:0] OP_RESTORE = 2'h1;
  localparam [1:0] OP_RELOAD  = 2'h2;

  reg  [2:0]  state;         // drive state
  reg  [2:0]  next_state;    // combinational next
  reg  [15:0] ctrl_word;     // last control word
  reg         cw_new;        // control word written last cycle
  reg         freset_prev;   // fault reset bit history
  reg  [7:0]  op_mode;       // mode of operation
  reg  [15:0] qs_option;     // quick stop option code
  reg  [7:0]  motion_sign_select;
  reg  [31:0] target_vel;    // speed command
  reg  [31:0] accel_step;    // ramp step per cycle
  reg  [31:0] hbeat_time;    // comm group word
  reg  [31:0] brake_delay;   // maker group word
  reg  [31:0] act_vel;       // ramped actual speed
  reg  [31:0] brake_cnt;     // cycles since running
  reg  [1:0]  sto_sync;      // pin synchronisers
  reg  [1:0]  stop_sync;
  reg  [1:0]  fault_sync;
  reg         cp_busy;       // copy engine state
  reg         cp_phase;
  reg  [1:0]  cp_op;
  reg  [1:0]  cp_idx;
  reg  [1:0]  cp_last;
  reg  [1:0]  rng_first;     // subindex decode
  reg  [1:0]  rng_last;
  reg         rng_ok;
  reg  [31:0] live_word;     // live word at copy index
  wire [31:0] nv_rdata;
  wire        nv_we;
  wire [31:0] nv_wdata;
  wire [2:0]  nv_raddr;
  wire        sto_s   = sto_sync[1];
  wire        stop_s  = stop_sync[1];
  wire        fault_s = fault_sync[1];
  wire        freset_rise = ctrl_word[`DPS_CW_FRESET] & ~freset_prev;
  wire [31:0] signed_tgt;
  wire [31:0] dem_vel;
  wire [32:0] vel_diff;
  wire        vel_up;
  wire        vel_dn;

  // two-stage synchronisers for asynchronous pins
  always @(posedge sys_clk or negedge resetn)
  begin
    if (!resetn)
    begin
      sto_sync   <= 2'h0;
      stop_sync  <= 2'h0;
      fault_sync <= 2'h0;
    end
    else
    begin
      sto_sync   <= {sto_sync[0], safe_torque_off_command};
      stop_sync  <= {stop_sync[0], stop_request};
      fault_sync <= {fault_sync[0], fault_detect};
    end
  end

  // next drive state; safety first, then fault, then commands
  always @*
  begin
    next_state = state;
    if (sto_s)
      next_state = ST_SOD;
    else if (fault_s && state != ST_FREACT && state != ST_FAULT)
      next_state = ST_FREACT;
    else
      case (state)
        ST_SOD:
          if (cw_new && ctrl_word[7:0] == `DPS_CW_SHUTDOWN)
            next_state = ST_READY;
        ST_READY:
          if (cw_new && !ctrl_word[`DPS_CW_EV])
            next_state = ST_SOD;
          else if (cw_new && ctrl_word[7:0] == `DPS_CW_SWITCH_ON)
            next_state = ST_SWON;
        ST_SWON:
          if (cw_new && !ctrl_word[`DPS_CW_EV])
            next_state = ST_SOD;
          else if (cw_new && ctrl_word[7:0] == `DPS_CW_ENABLE)
            next_state = ST_RUN;
          else if (cw_new && ctrl_word[7:0] == `DPS_CW_SHUTDOWN)
            next_state = ST_READY;
        ST_RUN:
          if (stop_s)
            next_state = ST_QHALT;
          else if (cw_new && !ctrl_word[`DPS_CW_EV])
            next_state = ST_SOD;
          else if (cw_new && !ctrl_word[`DPS_CW_QS])
            next_state = ST_QHALT;
          else if (cw_new && ctrl_word[7:0] == `DPS_CW_SWITCH_ON)
            next_state = ST_SWON;
          else if (cw_new && ctrl_word[7:0] == `DPS_CW_SHUTDOWN)
            next_state = ST_READY;
        ST_QHALT:
          // standstill with option 0 drops to disabled
          if (act_vel == 32'h0 && qs_option == `DPS_QSOPT_TO_SOD)
            next_state = ST_SOD;
          else if (cw_new && !ctrl_word[`DPS_CW_EV])
            next_state = ST_SOD;
        ST_FREACT:
          next_state = ST_FAULT;
        ST_FAULT:
          if (!fault_s && freset_rise)
            next_state = ST_SOD;
        default:
          next_state = ST_SOD;
      endcase
  end

  // state register
  always @(posedge sys_clk or negedge resetn)
  begin
    if (!resetn)
      state <= ST_SOD;
    else
      state <= next_state;
  end

  // demand: signed target only while running and not halted
  assign signed_tgt = motion_sign_select[`DPS_SIGN_VEL] ? (32'h0 - target_vel)
                      : target_vel;
  assign dem_vel  = (state == ST_RUN && !ctrl_word[`DPS_CW_HALT]) ? signed_tgt
                    : 32'h0;
  assign vel_diff = {dem_vel[31], dem_vel} - {act_vel[31], act_vel};
  assign vel_up   = !vel_diff[32] && vel_diff != 33'h0;
  assign vel_dn   = vel_diff[32];

  // speed ramp, brake timing and registered drive outputs
  always @(posedge sys_clk or negedge resetn)
  begin
    if (!resetn)
    begin
      act_vel         <= 32'h0;
      brake_cnt       <= 32'h0;
      amp_standby     <= 1'b0;
      drive_enable    <= 1'b0;
      motor_power     <= 1'b0;
      brake_release   <= 1'b0;
      velocity_demand <= 32'h0;
      pos_demand      <= 32'h0;
      status_word     <= `DPS_SW_SOD;
    end
    else
    begin
      // unpowered or faulted: speed drops to zero at once
      if (sto_s || fault_s || (state != ST_RUN && state != ST_QHALT))
        act_vel <= 32'h0;
      else if (vel_up)
        act_vel <= (vel_diff > {1'b0, accel_step}) ? act_vel + accel_step
                   : dem_vel;
      else if (vel_dn)
        act_vel <= (({33{1'b0}} - vel_diff) > {1'b0, accel_step})
                   ? act_vel - accel_step : dem_vel;
      // brake opens after the configured delay in running
      if (state == ST_RUN || state == ST_QHALT)
      begin
        if (brake_cnt < brake_delay)
          brake_cnt <= brake_cnt + 32'h1;
      end
      else
        brake_cnt <= 32'h0;
      brake_release   <= (state == ST_RUN || state == ST_QHALT)
                         && brake_cnt >= brake_delay;
      amp_standby     <= (state == ST_SWON);
      drive_enable    <= (state == ST_RUN || state == ST_QHALT) && !sto_s && !fault_s;
      motor_power     <= (state == ST_RUN || state == ST_QHALT) && !sto_s;
      velocity_demand <= dem_vel;
      pos_demand      <= motion_sign_select[`DPS_SIGN_POS] ? (32'h0 - pos_request)
                         : pos_request;
      // status codes; fault reaction shows as fault
      case (state)
        ST_READY:  status_word <= `DPS_SW_READY;
        ST_SWON:   status_word <= `DPS_SW_SWON;
        ST_RUN:    status_word <= `DPS_SW_RUN;
        ST_QHALT:  status_word <= `DPS_SW_QHALT;
        ST_FREACT: status_word <= `DPS_SW_FAULT;
        ST_FAULT:  status_word <= `DPS_SW_FAULT;
        default:   status_word <= `DPS_SW_SOD;
      endcase
    end
  end

  // subindex to word range of one parameter group
  always @*
  begin
    rng_ok    = 1'b1;
    rng_first = `DPS_NV_HBEAT;
    rng_last  = `DPS_NV_BRAKE;
    case (od_sub)
      `DPS_SUB_ALL:  rng_last = `DPS_NV_BRAKE;
      `DPS_SUB_COMM: rng_last = `DPS_NV_HBEAT;
      `DPS_SUB_APP:
      begin
        rng_first = `DPS_NV_SIGN;
        rng_last  = `DPS_NV_ACCEL;
      end
      `DPS_SUB_MFR:  rng_first = `DPS_NV_BRAKE;
      default:       rng_ok = 1'b0;
    endcase
  end

  // live word feeding a store
  always @*
  begin
    case (cp_idx)
      `DPS_NV_HBEAT: live_word = hbeat_time;
      `DPS_NV_SIGN:  live_word = {24'h0, motion_sign_select};
      `DPS_NV_ACCEL: live_word = accel_step;
      default:       live_word = brake_delay;
    endcase
  end

  // memory side of the copy engine; restore reads factory area
  assign nv_raddr = {cp_op == OP_RESTORE, cp_idx};
  assign nv_we    = cp_busy && cp_phase && cp_op != OP_RELOAD;
  assign nv_wdata = (cp_op == OP_STORE) ? live_word : nv_rdata;

  // object access, live parameters and copy engine
  always @(posedge sys_clk or negedge resetn)
  begin
    if (!resetn)
    begin
      od_rdata           <= 32'h0;
      od_ack             <= 1'b0;
      od_err             <= 1'b0;
      ctrl_word          <= 16'h0;
      cw_new             <= 1'b0;
      freset_prev        <= 1'b0;
      op_mode            <= `DPS_MODE_RST;
      qs_option          <= `DPS_QSOPT_RST;
      motion_sign_select <= `DPS_SIGN_RST;
      target_vel         <= 32'h0;
      accel_step         <= `DPS_GOLD_ACCEL;
      hbeat_time         <= `DPS_GOLD_HBEAT;
      brake_delay        <= `DPS_BRAKE_CYC;
      store_locked       <= 1'b0;
      cp_busy            <= 1'b0;
      cp_phase           <= 1'b0;
      cp_op              <= OP_STORE;
      cp_idx             <= 2'h0;
      cp_last            <= 2'h0;
    end
    else
    begin
      od_ack      <= od_wr | od_rd;
      od_err      <= 1'b0;
      cw_new      <= 1'b0;
      freset_prev <= ctrl_word[`DPS_CW_FRESET];
      if (stop_s || fault_s)
        target_vel <= 32'h0;
      // object writes; all parameter objects refuse edits while locked
      if (od_wr)
        case (od_index)
          `DPS_OBJ_CTRL:
          begin
            ctrl_word <= od_wdata[15:0];
            cw_new    <= 1'b1;
          end
          `DPS_OBJ_TGT_VEL:
            target_vel <= od_wdata;
          `DPS_OBJ_MODE:
            if (store_locked) od_err <= 1'b1;
            else op_mode <= od_wdata[7:0];
          `DPS_OBJ_QSOPT:
            if (store_locked) od_err <= 1'b1;
            else qs_option <= od_wdata[15:0];
          `DPS_OBJ_SIGN:
            if (store_locked) od_err <= 1'b1;
            else motion_sign_select <= {od_wdata[`DPS_SIGN_POS:`DPS_SIGN_VEL], 6'h0};
          `DPS_OBJ_ACCEL:
            if (store_locked) od_err <= 1'b1;
            else accel_step <= od_wdata;
          `DPS_OBJ_HBEAT:
            if (store_locked) od_err <= 1'b1;
            else hbeat_time <= od_wdata;
          `DPS_OBJ_BRAKE:
            if (store_locked) od_err <= 1'b1;
            else brake_delay <= od_wdata;
          `DPS_OBJ_STORE, `DPS_OBJ_RESTORE:
            if (cp_busy || !rng_ok) od_err <= 1'b1;
            // wrong signature is acknowledged and dropped
            else if ((od_index == `DPS_OBJ_STORE && od_wdata == `DPS_SIG_SAVE)
                     || (od_index == `DPS_OBJ_RESTORE && od_wdata == `DPS_SIG_LOAD))
            begin
              cp_busy  <= 1'b1;
              cp_phase <= 1'b0;
              cp_op    <= (od_index == `DPS_OBJ_STORE) ? OP_STORE : OP_RESTORE;
              cp_idx   <= rng_first;
              cp_last  <= rng_last;
            end
          default:
            od_err <= 1'b1;
        endcase
      // object reads
      if (od_rd)
        case (od_index)
          `DPS_OBJ_CTRL:      od_rdata <= {16'h0, ctrl_word};
          `DPS_OBJ_STAT:      od_rdata <= {16'h0, status_word};
          `DPS_OBJ_MODE:      od_rdata <= {24'h0, op_mode};
          `DPS_OBJ_MODE_DISP: od_rdata <= {24'h0, op_mode};
          `DPS_OBJ_QSOPT:     od_rdata <= {16'h0, qs_option};
          `DPS_OBJ_SIGN:      od_rdata <= {24'h0, motion_sign_select};
          `DPS_OBJ_TGT_VEL:   od_rdata <= target_vel;
          `DPS_OBJ_ACT_VEL:   od_rdata <= act_vel;
          `DPS_OBJ_ACCEL:     od_rdata <= accel_step;
          `DPS_OBJ_HBEAT:     od_rdata <= hbeat_time;
          `DPS_OBJ_BRAKE:     od_rdata <= brake_delay;
          default:
          begin
            od_rdata <= 32'h0;
            od_err   <= 1'b1;
          end
        endcase
      // copy engine: address phase, then data phase per word
      if (cp_busy)
      begin
        cp_phase <= ~cp_phase;
        if (cp_phase)
        begin
          if (cp_op == OP_RELOAD)
            case (cp_idx)
              `DPS_NV_HBEAT: hbeat_time <= nv_rdata;
              `DPS_NV_SIGN:  motion_sign_select <= {nv_rdata[`DPS_SIGN_POS:`DPS_SIGN_VEL], 6'h0};
              `DPS_NV_ACCEL: accel_step <= nv_rdata;
              default:       brake_delay <= nv_rdata;
            endcase
          if (cp_idx == cp_last)
            cp_busy <= 1'b0;
          else
            cp_idx <= cp_idx + 2'h1;
        end
      end
      // nmt resets reload the stored words
      if (nmt_reset_node || nmt_reset_comm)
      begin
        cp_busy  <= 1'b1;
        cp_phase <= 1'b0;
        cp_op    <= OP_RELOAD;
        cp_idx   <= `DPS_NV_HBEAT;
        cp_last  <= `DPS_NV_BRAKE;
      end
      if (nmt_reset_comm)
        store_locked <= 1'b0;
      // completion of a store sets the lock, winning over a clear
      if (cp_busy && cp_phase && cp_idx == cp_last && cp_op == OP_STORE)
        store_locked <= 1'b1;
    end
  end

  // parameter memory with protected factory area
  dps_nvm u_nvm
  (
    .sys_clk  (sys_clk),
    .nv_we    (nv_we),
    .nv_waddr ({1'b0, cp_idx}),
    .nv_wdata (nv_wdata),
    .nv_raddr (nv_raddr),
    .nv_rdata (nv_rdata)
  );
endmodule // dps_drive_ctrl

// ### dps_host_model.sv
/*
  fieldbus host on the object port: one-cycle requests, answer taken.
  assumes requests start at falling edges of sys_clk.
*/
`timescale 1ns/1ps
module dps_host_model
(
  input  wire        sys_clk,
  input  wire [31:0] od_rdata,
  input  wire        od_ack,
  input  wire        od_err,
  output reg         od_wr,
  output reg         od_rd,
  output reg  [15:0] od_index,
  output reg  [7:0]  od_sub,
  output reg  [31:0] od_wdata
);
  reg [31:0] rd; // last read value
  reg        er; // last refusal
  reg        ok; // answer seen in time
  initial {od_wr, od_rd, od_index, od_sub, od_wdata} = 0;
  // pulse a request, clear wr and rd, invert index and data, wait for answer
  task xfer(input w, input [15:0] i, input [7:0] s, input [31:0] d);
    integer k;
    begin
      @(negedge sys_clk);
      {od_wr, od_rd, od_index, od_sub, od_wdata} = {w, !w, i, s, d};
      @(negedge sys_clk);
      {od_wr, od_rd, od_index, od_wdata} = {2'b00, ~i, ~d};
      ok = 0;
      for (k = 0; k < 4 && !ok; k = k + 1)
      begin
        if (od_ack === 1'b1)
        begin
          ok = 1;
          rd = od_rdata;
          er = od_err;
        end
        else
          @(negedge sys_clk);
      end
    end
  endtask
endmodule // dps_host_model

// ### dps_nvm.v
/*
  nonvolatile parameter memory: four user words and a read-only
  factory area of four words; read data come out of a register.
  assumes the user array keeps its contents across resetn.
*/
`timescale 1ns/1ps
`include "dps_consts.vh"
module dps_nvm
(
  input  wire        sys_clk,
  input  wire        nv_we,
  input  wire [2:0]  nv_waddr,
  input  wire [31:0] nv_wdata,
  input  wire [2:0]  nv_raddr,
  output reg  [31:0] nv_rdata
);
  reg [31:0] user_mem [0:3];  // user area, no reset
  reg [31:0] gold;            // factory word at read address

  // factory area is a constant table, cannot be written
  always @*
  begin
    case (nv_raddr[1:0])
      `DPS_NV_HBEAT: gold = `DPS_GOLD_HBEAT;
      `DPS_NV_SIGN:  gold = `DPS_GOLD_SIGN;
      `DPS_NV_ACCEL: gold = `DPS_GOLD_ACCEL;
      default:       gold = `DPS_BRAKE_CYC;
    endcase
  end

  // writes land in the user area only
  always @(posedge sys_clk)
  begin
    if (nv_we && !nv_waddr[2])
      user_mem[nv_waddr[1:0]] <= nv_wdata;
    nv_rdata <= nv_raddr[2] ? gold : user_mem[nv_raddr[1:0]];
  end
endmodule // dps_nvm

// ### dps_sva.sv
/*
  port checker for dps_drive_ctrl.
  assumes it is bound onto the top module.
*/
`timescale 1ns/1ps
`include "dps_consts.vh"
module dps_sva
(
  input wire        sys_clk,
  input wire        resetn,
  input wire        od_wr,
  input wire        od_rd,
  input wire [15:0] od_index,
  input wire [31:0] od_wdata,
  input wire        od_ack,
  input wire        od_err,
  input wire        nmt_reset_comm,
  input wire        safe_torque_off_command,
  input wire        fault_detect,
  input wire        amp_standby,
  input wire        drive_enable,
  input wire        motor_power,
  input wire [31:0] velocity_demand,
  input wire [15:0] status_word,
  input wire        store_locked
);
  default clocking cb @(posedge sys_clk); endclocking
  default disable iff (!resetn);
  // store write carrying the save word
  sequence s_save;
    od_wr && od_index == `DPS_OBJ_STORE && od_wdata == `DPS_SIG_SAVE;
  endsequence
  // store write with a wrong word while unlocked
  sequence s_junk;
    od_wr && od_index == `DPS_OBJ_STORE && od_wdata != `DPS_SIG_SAVE && !store_locked;
  endsequence
  property p_ack; od_wr || od_rd |=> od_ack; endproperty
  property p_save; s_save |-> ##[8:10] store_locked; endproperty
  property p_junk; s_junk |=> !od_err ##0 (!store_locked) [*8]; endproperty
  property p_lock; store_locked && od_wr && od_index == `DPS_OBJ_SIGN |=> od_err; endproperty
  property p_unlock; nmt_reset_comm |-> ##[1:2] !store_locked; endproperty
  property p_swon; status_word == `DPS_SW_SWON |-> amp_standby && !drive_enable; endproperty
  // status lags one cycle behind a safety or fault stop, so skip while a pin is up
  property p_run; status_word == `DPS_SW_RUN && !safe_torque_off_command && !fault_detect
    |-> drive_enable && motor_power; endproperty
  property p_flt; status_word == `DPS_SW_FAULT |-> !drive_enable && velocity_demand == 0; endproperty
  property p_off; safe_torque_off_command [*6] |-> !motor_power && velocity_demand == 0; endproperty
  property p_det; fault_detect [*6] |-> status_word == `DPS_SW_FAULT; endproperty
  a_ack: assert property (p_ack) else $error("request without answer");
  a_save: assert property (p_save) else $error("store did not lock");
  a_junk: assert property (p_junk) else $error("wrong word acted on");
  a_lock: assert property (p_lock) else $error("locked write taken");
  a_unlock: assert property (p_unlock) else $error("lock not cleared");
  a_swon: assert property (p_swon) else $error("switched on outputs wrong");
  a_run: assert property (p_run) else $error("running outputs wrong");
  a_flt: assert property (p_flt) else $error("fault outputs wrong");
  a_off: assert property (p_off) else $error("safety stop ignored");
  a_det: assert property (p_det) else $error("fault not entered");
endmodule // dps_sva
bind dps_drive_ctrl dps_sva u_sva (.sys_clk(sys_clk), .resetn(resetn), .od_wr(od_wr), .od_rd(od_rd),
  .od_index(od_index), .od_wdata(od_wdata), .od_ack(od_ack), .od_err(od_err), .nmt_reset_comm(nmt_reset_comm),
  .safe_torque_off_command(safe_torque_off_command), .fault_detect(fault_detect), .amp_standby(amp_standby),
  .drive_enable(drive_enable), .motor_power(motor_power), .velocity_demand(velocity_demand),
  .status_word(status_word), .store_locked(store_locked));

// ### drive_state_and_param_store_bench.sv
/*
  bench for dps_drive_ctrl: bring-up, motion, stops, sign, store.
  assumes dps_host_model drives the object port.
*/
`timescale 1ns/1ps
`include "dps_consts.vh"
module drive_state_and_param_store_bench;
  reg         sys_clk = 0;
  reg         resetn = 0;
  reg         nmt_node = 0;
  reg         nmt_comm = 0;
  reg         safe_off = 0;
  reg         stop_pin = 0;
  reg         fault_pin = 0;
  reg  [31:0] pos_request = 0;
  reg  [31:0] v;
  integer     n_fail = 0, checks_done = 0, seed = 32'h3eb8, n;
  wire        od_wr, od_rd, od_ack, od_err, amp_standby, drive_enable, motor_power, brake_release, store_locked;
  wire [15:0] od_index, status_word;
  wire [7:0]  od_sub;
  wire [31:0] od_wdata, od_rdata, velocity_demand, pos_demand;
  always #25 sys_clk = ~sys_clk;
  dps_host_model u_host (.sys_clk(sys_clk), .od_rdata(od_rdata), .od_ack(od_ack), .od_err(od_err),
    .od_wr(od_wr), .od_rd(od_rd), .od_index(od_index), .od_sub(od_sub), .od_wdata(od_wdata));
  dps_drive_ctrl u_dps_drive_ctrl (.sys_clk(sys_clk), .resetn(resetn), .od_wr(od_wr), .od_rd(od_rd),
    .od_index(od_index), .od_sub(od_sub), .od_wdata(od_wdata), .od_rdata(od_rdata), .od_ack(od_ack),
    .od_err(od_err), .nmt_reset_node(nmt_node), .nmt_reset_comm(nmt_comm), .safe_torque_off_command(safe_off),
    .stop_request(stop_pin), .fault_detect(fault_pin), .pos_request(pos_request), .amp_standby(amp_standby),
    .drive_enable(drive_enable), .motor_power(motor_power), .brake_release(brake_release),
    .velocity_demand(velocity_demand), .pos_demand(pos_demand), .status_word(status_word),
    .store_locked(store_locked));
  // expected sign object: only bits 7 and 6 kept
  function [31:0] f_sign(input [31:0] d);
    f_sign = d & 32'h000000c0;
  endfunction
  task end_sim;
    begin
      if (n_fail == 0 && checks_done > 0)
        $display("bench passed");
      else
        $display("bench failed");
      $finish;
    end
  endtask
  // compare and count
  task chk(input string nm, input [31:0] e, input [31:0] g);
    begin
      checks_done = checks_done + 1;
      if (g !== e)
      begin
        n_fail = n_fail + 1;
        $display("unexpected %0s exp %h got %h", nm, e, g);
      end
    end
  endtask
  // one transfer; a missing answer ends the run
  task req(input w, input [15:0] i, input [7:0] s, input [31:0] d, input e);
    begin
      u_host.xfer(w, i, s, d);
      chk("answer", 1, u_host.ok);
      if (u_host.ok !== 1'b1)
        end_sim;
      chk("refusal", e, u_host.er);
    end
  endtask
  task rd(input [15:0] i, input [31:0] e);
    begin
      req(0, i, 8'h00, 0, 0);
      chk("read", e, u_host.rd);
    end
  endtask
  // bounded wait for a status code
  task waitst(input [15:0] e);
    begin
      for (n = 0; n < 200 && status_word !== e; n = n + 1)
        @(negedge sys_clk);
      chk("status", e, status_word);
      if (status_word !== e)
        end_sim;
    end
  endtask
  task gap(input integer c);
    repeat (c) @(negedge sys_clk);
  endtask
  // mode 3, then control 06, 07, 0f; bit 8 stays clear
  task bring_up;
    begin
      req(1, `DPS_OBJ_MODE, 0, 3, 0);
      req(1, `DPS_OBJ_CTRL, 0, `DPS_CW_SHUTDOWN, 0);
      req(1, `DPS_OBJ_CTRL, 0, `DPS_CW_SWITCH_ON, 0);
      waitst(`DPS_SW_SWON);
      rd(`DPS_OBJ_STAT, `DPS_SW_SWON);
      req(1, `DPS_OBJ_CTRL, 0, `DPS_CW_ENABLE, 0);
      waitst(`DPS_SW_RUN);
    end
  endtask
  task pulse(input c);
    begin
      nmt_comm = c;
      nmt_node = !c;
      gap(1);
      {nmt_comm, nmt_node} = 2'b00;
      gap(12);
    end
  endtask
  initial
  begin
    gap(10);
    resetn = 1;
    rd(`DPS_OBJ_STAT, `DPS_SW_SOD);
    rd(`DPS_OBJ_SIGN, `DPS_SIGN_RST);
    req(1, 16'h5a5a, 0, 0, 1);
    req(1, `DPS_OBJ_BRAKE, 0, 4, 0);
    for (n = 0; n < 4; n = n + 1)
    begin
      v = $random(seed);
      req(1, `DPS_OBJ_SIGN, 0, v, 0);
      rd(`DPS_OBJ_SIGN, f_sign(v));
    end
    req(1, `DPS_OBJ_SIGN, 0, 8'h80, 0);
    bring_up;
    gap(8);
    chk("brake", 1, brake_release);
    pos_request = $random(seed);
    gap(3);
    chk("pos", -pos_request, pos_demand);
    req(1, `DPS_OBJ_TGT_VEL, 0, 32'h3e8, 0);
    gap(20);
    rd(`DPS_OBJ_ACT_VEL, 32'h3e8);
    req(1, `DPS_OBJ_SIGN, 0, 8'h40, 0);
    gap(30);
    chk("veldem", -32'h3e8, velocity_demand);
    stop_pin = 1;
    waitst(`DPS_SW_QHALT);
    chk("bit5", 0, status_word[5]);
    waitst(`DPS_SW_SOD);
    stop_pin = 0;
    bring_up;
    safe_off = 1;
    waitst(`DPS_SW_SOD);
    chk("power", 0, motor_power);
    safe_off = 0;
    bring_up;
    fault_pin = 1;
    waitst(`DPS_SW_FAULT);
    chk("bit3", 1, status_word[3]);
    req(1, `DPS_OBJ_ACCEL, 0, 32'h64, 0);
    fault_pin = 0;
    gap(4);
    req(1, `DPS_OBJ_CTRL, 0, 8'h80, 0);
    waitst(`DPS_SW_SOD);
    req(1, `DPS_OBJ_RESTORE, `DPS_SUB_ALL, `DPS_SIG_LOAD, 0);
    gap(12);
    req(1, `DPS_OBJ_STORE, `DPS_SUB_APP, 32'h12345678, 0);
    gap(12);
    chk("lock", 0, store_locked);
    for (v = 2; v < 5; v = v + 1)
    begin
      req(1, `DPS_OBJ_SIGN, 0, 8'h80, 0);
      req(1, `DPS_OBJ_STORE, v[7:0], `DPS_SIG_SAVE, 0);
      gap(12);
      chk("lock", 1, store_locked);
      req(1, `DPS_OBJ_SIGN, 0, 0, 1);
      req(1, `DPS_OBJ_CTRL, 0, 0, 0);
      pulse(1);
    end
    req(1, `DPS_OBJ_SIGN, 0, 8'h40, 0);
    pulse(0);
    rd(`DPS_OBJ_SIGN, 8'h80);
    req(1, `DPS_OBJ_RESTORE, `DPS_SUB_ALL, `DPS_SIG_LOAD, 0);
    gap(12);
    pulse(1);
    rd(`DPS_OBJ_SIGN, 0);
    end_sim;
  end
endmodule // drive_state_and_param_store_bench
